// >>> src/sdm_cfg.svh
// Purpose: Constants of the shared display memory interface.
// Assumes: 50 MHz system clock.
// Notes:   Definitions only.
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH

// Microcontroller address windows.
`define SDM_AUX_LO        16'h0000
`define SDM_AUX_HI        16'h07FF
`define SDM_TELE_LO       16'h2000
`define SDM_TELE_HI       16'h47FF
`define SDM_CAP_LO        16'h8000
`define SDM_CAP_HI        16'h84FF
`define SDM_CAP_USED_HI   16'h845F

// Storage sizes.
`define SDM_AUX_DEPTH     2048
`define SDM_DISP_DEPTH    10240
`define SDM_DISP_LAST     14'h27FF
`define SDM_NUM_BLOCKS    4'hA

// Fill value for display storage after power-up and reset.
`define SDM_FILL_CHAR     8'h20

// Teletext page geometry.
`define SDM_LAST_COL      6'h27
`define SDM_LAST_ROW      5'h19
`define SDM_LAST_ROW_COL  6'h17
`define SDM_HI_COL_FIRST  6'h20
`define SDM_HI_COL_BASE   10'h3F8

// Register reset values.
`define SDM_BLK_RST       4'h0
`define SDM_ROW_RST       5'h00
`define SDM_COL_RST       6'h00

// Refresh slot interval.
`define SDM_REF_PERIOD_NS 1280
`define SDM_CLK_PERIOD_NS 20
`define SDM_REF_CYCLES    (`SDM_REF_PERIOD_NS / `SDM_CLK_PERIOD_NS)

`endif

// >>> src/sdm_pkg.sv
// Purpose: Types of the shared display memory interface.
// Assumes: Constants come from sdm_cfg.svh.
// Notes:   Types only.
`default_nettype none
package sdm_pkg;

  // Register selected on the special function register port.
  typedef enum logic [1:0] {
    SDM_RSEL_BLOCK,
    SDM_RSEL_ROW,
    SDM_RSEL_COL,
    SDM_RSEL_DATA
  } sdm_rsel_t;

  // Region hit by an external move instruction address.
  typedef enum logic [1:0] {
    SDM_REG_NONE,
    SDM_REG_AUX,
    SDM_REG_DISP
  } sdm_region_t;

  typedef struct packed {
    sdm_region_t region;
    logic [13:0] idx;
  } sdm_xm_dec_t;

  // One storage operation per cycle.
  typedef struct packed {
    logic        aux_we;
    logic        disp_we;
    logic [13:0] idx;
    logic [7:0]  data;
  } sdm_memop_t;

  // Whole state of the interface.
  typedef struct packed {
    logic [3:0]  blk;
    logic [4:0]  row;
    logic [5:0]  col;
    logic        fill_busy;
    logic [13:0] fill_idx;
    logic [7:0]  ref_cnt;
    logic        ref_pend;
    logic        xm_ack;
    logic [7:0]  xm_rdata;
    logic        rp_ack;
    logic [7:0]  rp_rdata;
    logic        cap_ack;
    logic        disp_ack;
    logic [7:0]  disp_rdata;
  } sdm_state_t;

endpackage : sdm_pkg
`default_nettype wire

// >>> src/sdm_cell_map.sv
// Purpose: Maps a teletext row and column to the low ten address bits.
// Assumes: Row 0..25 and column 0..39.
// Notes:   Purely combinational.
`timescale 1ns/10ps
`default_nettype none
`include "sdm_cfg.svh"
module sdm_cell_map
  import sdm_pkg::*;
(
  // Cell position
  input  wire logic [4:0] row_i,
  input  wire logic [5:0] col_i,
  // Offset within the block
  output logic      [9:0] off_o
);

  always_comb begin
    if (col_i < `SDM_HI_COL_FIRST) begin
      off_o = {row_i, col_i[4:0]};
    end else begin
      // Columns 32..39 sit in 8-byte groups counting down from the top.
      off_o = (`SDM_HI_COL_BASE - {2'b00, row_i, 3'b000}) | {7'h00, col_i[2:0]};
    end
  end

endmodule : sdm_cell_map
`default_nettype wire

// >>> src/sdm_mem_if.sv
// Purpose: Shared display memory interface for microcontroller, capture and display.
// Assumes: Requesters hold their request until the matching acknowledge pulse.
// Notes:   One storage access per cycle; fill after reset has top priority.
//
// Overview of operation
// - One shared memory serves capture, display, microcontroller, plus refresh and clearing.
// - Auxiliary RAM is 2 kbytes at 0000H..07FFH, via external move only.
// - Display RAM at 2000H..47FFH and 8000H..84FFH maps to one storage.
// - Caption window and auxiliary RAM are reachable only by external move.
// - Teletext window is reachable by external move and by the register path.
// - Idle display RAM may be used by the microcontroller as extra RAM.
// - Caption uses 8000H..845FH; the rest up to 84FFH is spare RAM.
// - Auxiliary RAM is never initialised by hardware; idle keeps it.
// - Display RAM is filled with 20H at power-up; idle keeps it.
// - Leaving idle by reset refills display RAM; by interrupt keeps it.
// - A teletext page is 40 columns by 25 rows plus a 24-column row 25, one kilobyte.
// - A 4-bit block select chooses the page for the register path.
// - Row and column fields pick the cell; data register reads or writes it.
// - Each data access advances the column; after 39 the row advances.
// - Reaching row 25 column 23 returns row and column to zero.
// - Move access address is block base plus row and column offset.
// - Low ten bits are row*32+column, or descending groups from 3F8H.
`timescale 1ns/10ps
`default_nettype none
`include "sdm_cfg.svh"
module sdm_mem_if
  import sdm_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // External move instruction port
  input  wire logic        xm_req_i,
  input  wire logic        xm_we_i,
  input  wire logic [15:0] xm_addr_i,
  input  wire logic [7:0]  xm_wdata_i,
  output logic             xm_ack_o,
  output logic      [7:0]  xm_rdata_o,
  // Special function register port
  input  wire logic        rp_req_i,
  input  wire logic        rp_we_i,
  input  wire sdm_rsel_t   rp_sel_i,
  input  wire logic [7:0]  rp_wdata_i,
  output logic             rp_ack_o,
  output logic      [7:0]  rp_rdata_o,
  // Data capture write port
  input  wire logic        cap_req_i,
  input  wire logic [13:0] cap_addr_i,
  input  wire logic [7:0]  cap_wdata_i,
  output logic             cap_ack_o,
  // Display read port
  input  wire logic        disp_req_i,
  input  wire logic [13:0] disp_addr_i,
  output logic             disp_ack_o,
  output logic      [7:0]  disp_rdata_o,
  // Status
  output logic             fill_busy_o
);

  sdm_state_t  st_r;
  sdm_state_t  st_nxt;
  sdm_memop_t  op;
  sdm_xm_dec_t xm_dec;
  logic [9:0]  cell_off;
  logic [13:0] rp_idx;

  // No reset on the arrays: auxiliary contents survive idle and are never cleared.
  logic [7:0]  aux_mem  [0:`SDM_AUX_DEPTH-1];
  logic [7:0]  disp_mem [0:`SDM_DISP_DEPTH-1];

  function automatic logic disp_ok(input logic [13:0] idx);
    disp_ok = (idx <= `SDM_DISP_LAST);
  endfunction : disp_ok

  // Both display windows land on the same storage, offset from their base.
  function automatic sdm_xm_dec_t xm_decode(input logic [15:0] a);
    sdm_xm_dec_t d;
    d.region = SDM_REG_NONE;
    d.idx    = 14'h0000;
    if (a <= `SDM_AUX_HI) begin
      d.region = SDM_REG_AUX;
      d.idx    = {3'b000, a[10:0]};
    end else if (a >= `SDM_TELE_LO && a <= `SDM_TELE_HI) begin
      d.region = SDM_REG_DISP;
      d.idx    = 14'(a - `SDM_TELE_LO);
    end else if (a >= `SDM_CAP_LO && a <= `SDM_CAP_HI) begin
      d.region = SDM_REG_DISP;
      d.idx    = 14'(a - `SDM_CAP_LO);
    end
    xm_decode = d;
  endfunction : xm_decode

  function automatic logic is_last_col(input logic [4:0] r, input logic [5:0] c);
    is_last_col = (r == `SDM_LAST_ROW) ? (c == `SDM_LAST_ROW_COL) : (c == `SDM_LAST_COL);
  endfunction : is_last_col

  sdm_cell_map u_cell_map (
    .row_i (st_r.row),
    .col_i (st_r.col),
    .off_o (cell_off)
  );

  // Block base plus cell offset, the same image a move access sees.
  assign rp_idx = {st_r.blk, cell_off};

  assign xm_dec = xm_decode(xm_addr_i);

  always_comb begin
    st_nxt          = st_r;
    st_nxt.xm_ack   = 1'b0;
    st_nxt.rp_ack   = 1'b0;
    st_nxt.cap_ack  = 1'b0;
    st_nxt.disp_ack = 1'b0;
    op              = '0;

    // Single grant per cycle in fixed priority order.
    if (st_r.fill_busy) begin
      op.disp_we = 1'b1;
      op.idx     = st_r.fill_idx;
      op.data    = `SDM_FILL_CHAR;
      if (st_r.fill_idx == `SDM_DISP_LAST) begin
        st_nxt.fill_busy = 1'b0;
      end else begin
        st_nxt.fill_idx = st_r.fill_idx + 14'h0001;
      end
    end else if (st_r.ref_pend) begin
      st_nxt.ref_pend = 1'b0;
    end else if (disp_req_i && !st_r.disp_ack) begin
      st_nxt.disp_ack   = 1'b1;
      st_nxt.disp_rdata = disp_ok(disp_addr_i) ? disp_mem[disp_addr_i] : 8'h00;
    end else if (cap_req_i && !st_r.cap_ack) begin
      st_nxt.cap_ack = 1'b1;
      if (disp_ok(cap_addr_i)) begin
        op.disp_we = 1'b1;
        op.idx     = cap_addr_i;
        op.data    = cap_wdata_i;
      end
    end else if (rp_req_i && !st_r.rp_ack) begin
      st_nxt.rp_ack = 1'b1;
      case (rp_sel_i)
        SDM_RSEL_BLOCK: begin
          if (rp_we_i) begin
            st_nxt.blk = rp_wdata_i[3:0];
          end
          st_nxt.rp_rdata = {4'h0, st_r.blk};
        end
        SDM_RSEL_ROW: begin
          if (rp_we_i) begin
            st_nxt.row = rp_wdata_i[4:0];
          end
          st_nxt.rp_rdata = {3'b000, st_r.row};
        end
        SDM_RSEL_COL: begin
          if (rp_we_i) begin
            st_nxt.col = rp_wdata_i[5:0];
          end
          st_nxt.rp_rdata = {2'b00, st_r.col};
        end
        SDM_RSEL_DATA: begin
          // Blocks beyond the last page read zero and drop writes.
          if (st_r.blk < `SDM_NUM_BLOCKS) begin
            st_nxt.rp_rdata = disp_mem[rp_idx];
            op.disp_we      = rp_we_i;
            op.idx          = rp_idx;
            op.data         = rp_wdata_i;
          end else begin
            st_nxt.rp_rdata = 8'h00;
          end
          // Out-of-range pointers from software give undefined stepping.
          if (st_r.row == `SDM_LAST_ROW && st_r.col == `SDM_LAST_ROW_COL) begin
            st_nxt.row = `SDM_ROW_RST;
            st_nxt.col = `SDM_COL_RST;
          end else if (is_last_col(st_r.row, st_r.col)) begin
            st_nxt.col = `SDM_COL_RST;
            st_nxt.row = st_r.row + 5'h01;
          end else begin
            st_nxt.col = st_r.col + 6'h01;
          end
        end
        default: begin
          st_nxt.rp_rdata = 8'h00;
        end
      endcase
    end else if (xm_req_i && !st_r.xm_ack) begin
      st_nxt.xm_ack = 1'b1;
      case (xm_dec.region)
        SDM_REG_AUX: begin
          st_nxt.xm_rdata = aux_mem[xm_dec.idx[10:0]];
          op.aux_we       = xm_we_i;
        end
        SDM_REG_DISP: begin
          st_nxt.xm_rdata = disp_mem[xm_dec.idx];
          op.disp_we      = xm_we_i;
        end
        default: begin
          st_nxt.xm_rdata = 8'h00;
        end
      endcase
      op.idx  = xm_dec.idx;
      op.data = xm_wdata_i;
    end

    // A new refresh demand in the slot where the old one is served still counts.
    if (st_r.ref_cnt == 8'(`SDM_REF_CYCLES - 1)) begin
      st_nxt.ref_cnt  = 8'h00;
      st_nxt.ref_pend = 1'b1;
    end else begin
      st_nxt.ref_cnt = st_r.ref_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r           <= '0;
      st_r.blk       <= `SDM_BLK_RST;
      st_r.row       <= `SDM_ROW_RST;
      st_r.col       <= `SDM_COL_RST;
      st_r.fill_busy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (op.aux_we) begin
      aux_mem[op.idx[10:0]] <= op.data;
    end
    if (op.disp_we) begin
      disp_mem[op.idx] <= op.data;
    end
  end

  assign xm_ack_o     = st_r.xm_ack;
  assign xm_rdata_o   = st_r.xm_rdata;
  assign rp_ack_o     = st_r.rp_ack;
  assign rp_rdata_o   = st_r.rp_rdata;
  assign cap_ack_o    = st_r.cap_ack;
  assign disp_ack_o   = st_r.disp_ack;
  assign disp_rdata_o = st_r.disp_rdata;
  assign fill_busy_o  = st_r.fill_busy;

endmodule : sdm_mem_if
`default_nettype wire

// >>> testbench/sdm_mem_if_assertions.sv
// Purpose: Port checks of the shared display memory interface.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to sdm_mem_if from the bench top.
`timescale 1ns/10ps
`default_nettype none
module sdm_mem_if_assertions
  import sdm_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Requests, answers and fill status
  input  wire logic xm_req_i,
  input  wire logic xm_ack_o,
  input  wire logic rp_req_i,
  input  wire logic rp_ack_o,
  input  wire logic cap_req_i,
  input  wire logic cap_ack_o,
  input  wire logic disp_req_i,
  input  wire logic disp_ack_o,
  input  wire logic fill_busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Counts fill cycles since the last reset; 14 bits hold the full length.
  logic [13:0] fill_cnt_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fill_cnt_r <= 14'h0000;
    end else if (fill_busy_o) begin
      fill_cnt_r <= fill_cnt_r + 14'h0001;
    end
  end

  fill_len_a: assert property ($fell(fill_busy_o) |-> fill_cnt_r inside {[14'h2800:14'h2801]})
    else $error("fill length wrong");
  fill_bound_a: assert property (fill_busy_o |-> fill_cnt_r < 14'h2802)
    else $error("fill runs too long");
  fill_no_rise_a: assert property (!$rose(fill_busy_o))
    else $error("fill restarted without reset");
  fill_blocks_a: assert property (fill_busy_o |-> !(xm_ack_o || rp_ack_o || cap_ack_o || disp_ack_o))
    else $error("answer during fill");
  one_ack_a: assert property ($onehot0({xm_ack_o, rp_ack_o, cap_ack_o, disp_ack_o}))
    else $error("two answers at once");
  xm_pulse_a: assert property (xm_ack_o |-> $past(xm_req_i) ##1 !xm_ack_o)
    else $error("move answer bad");
  rp_pulse_a: assert property (rp_ack_o |-> $past(rp_req_i) ##1 !rp_ack_o)
    else $error("register answer bad");
  cap_cause_a: assert property (cap_ack_o |-> $past(cap_req_i) && !$past(fill_busy_o))
    else $error("capture answer bad");
  disp_fast_a: assert property (disp_req_i && !disp_ack_o && !fill_busy_o |-> ##[1:4] disp_ack_o)
    else $error("display answer late");
endmodule : sdm_mem_if_assertions
`default_nettype wire

// >>> testbench/sdm_far_side.sv
// Purpose: Capture writer and display reader at the storage far side.
// Assumes: cmd_i is a one-cycle pulse while no request is open.
// Notes:   Idle address and data lines show inverted values.
`timescale 1ns/10ps
`default_nettype none
module sdm_far_side
  import sdm_pkg::*;
(
  // Clock, reset and command
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cmd_i,
  input  wire logic        cmd_we_i,
  input  wire logic [13:0] cmd_addr_i,
  input  wire logic [7:0]  cmd_data_i,
  // Storage side
  output logic             cap_req_o,
  output logic      [13:0] cap_addr_o,
  output logic      [7:0]  cap_wdata_o,
  input  wire logic        cap_ack_i,
  output logic             disp_req_o,
  output logic      [13:0] disp_addr_o,
  input  wire logic        disp_ack_i,
  input  wire logic [7:0]  disp_rdata_i,
  // Result
  output logic      [7:0]  rd_o
);
  logic [13:0] addr_r;
  logic [7:0]  data_r;
  assign cap_addr_o  = cap_req_o ? addr_r : ~addr_r;
  assign cap_wdata_o = cap_req_o ? data_r : ~data_r;
  assign disp_addr_o = disp_req_o ? addr_r : ~addr_r;
  // Dropping in the answer cycle keeps one request from being served twice.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_req_o  <= 1'b0;
      disp_req_o <= 1'b0;
      addr_r     <= 14'h0000;
      data_r     <= 8'h00;
      rd_o       <= 8'h00;
    end else if (cmd_i) begin
      cap_req_o  <= cmd_we_i;
      disp_req_o <= !cmd_we_i;
      addr_r     <= cmd_addr_i;
      data_r     <= cmd_data_i;
    end else begin
      if (cap_ack_i) begin
        cap_req_o <= 1'b0;
      end
      if (disp_ack_i) begin
        disp_req_o <= 1'b0;
        rd_o       <= disp_rdata_i;
      end
    end
  end
endmodule : sdm_far_side
`default_nettype wire

// >>> testbench/test_sdm_mem_if.sv
// Purpose: Self-checking bench of the shared display memory interface.
// Assumes: 50 MHz clock; fill takes about 10240 cycles per reset.
// Notes:   Register path and move port share one access task.
`timescale 1ns/10ps
`default_nettype none
module test_sdm_mem_if import sdm_pkg::*; ();
  logic        sys_clk_i = 1'b0, rst_n_i, xm_req_i, xm_we_i, rp_req_i, rp_we_i;
  logic        cap_req_i, disp_req_i, xm_ack_o, rp_ack_o, cap_ack_o, disp_ack_o;
  logic        fill_busy_o, cmd, cmd_we;
  logic [15:0] xm_addr_i;
  logic [13:0] cap_addr_i, disp_addr_i, cmd_addr;
  logic [7:0]  xm_wdata_i, rp_wdata_i, xm_rdata_o, rp_rdata_o, disp_rdata_o;
  logic [7:0]  cap_wdata_i, cmd_data, rd;
  sdm_rsel_t   rp_sel_i;
  int          mismatches = 0, num_checks = 0;
  localparam logic X = 1'b0, S = 1'b1, W = 1'b1, R = 1'b0;
  localparam logic [15:0] BLK = 16'h0000, ROW = 16'h0001, COL = 16'h0002, DAT = 16'h0003;

  sdm_mem_if dut (.*);
  sdm_far_side far_side (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
    .cmd_we_i(cmd_we), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
    .cap_req_o(cap_req_i), .cap_addr_o(cap_addr_i), .cap_wdata_o(cap_wdata_i),
    .cap_ack_i(cap_ack_o), .disp_req_o(disp_req_i), .disp_addr_o(disp_addr_i),
    .disp_ack_i(disp_ack_o), .disp_rdata_i(disp_rdata_o), .rd_o(rd));

  always #10 sys_clk_i = ~sys_clk_i;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One access on the move port (s=0) or register port (s=1); reads compare e.
  task automatic acc(input logic s, input logic we, input logic [15:0] a,
                     input logic [7:0] d, input logic [7:0] e);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    xm_req_i    <= !s;
    rp_req_i    <= s;
    xm_we_i     <= we;
    rp_we_i     <= we;
    xm_addr_i   <= a;
    rp_sel_i    <= sdm_rsel_t'(a[1:0]);
    xm_wdata_i  <= d;
    rp_wdata_i  <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while ((s ? rp_ack_o : xm_ack_o) !== 1'b1 && n < 30000);
    // A handshake that never answers is a failure even for a write.
    if (n >= 30000) mismatches++;
    xm_req_i    <= 1'b0;
    rp_req_i    <= 1'b0;
    xm_addr_i   <= ~a;
    xm_wdata_i  <= ~d;
    rp_wdata_i  <= ~d;
    if (!we) chk(s ? rp_rdata_o : xm_rdata_o, e);
  endtask : acc

  task automatic far(input logic we, input logic [13:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cmd      <= 1'b1;
    cmd_we   <= we;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge sys_clk_i);
    cmd <= 1'b0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while ((cap_req_i | disp_req_i) !== 1'b0 && n < 30000);
    if (n >= 30000) mismatches++;
    if (!we) chk(rd, e);
  endtask : far

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {xm_req_i, xm_we_i, rp_req_i, rp_we_i, cmd, cmd_we, rst_n_i} = 7'h00;
    {xm_addr_i, xm_wdata_i, rp_wdata_i, cmd_addr, cmd_data} = 54'h0;
    rp_sel_i = SDM_RSEL_BLOCK;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    acc(X, R, 16'h2000, 8'h00, 8'h20);
    chk({7'h00, fill_busy_o}, 8'h00);
    acc(X, R, 16'h84FF, 8'h00, 8'h20);
    $display("test fill done");
    acc(X, W, 16'h07FF, 8'hA5, 8'h00);
    acc(X, R, 16'h07FF, 8'h00, 8'hA5);
    acc(X, W, 16'h1000, 8'h11, 8'h00);
    acc(X, R, 16'h1000, 8'h00, 8'h00);
    acc(X, W, 16'h2123, 8'h3C, 8'h00);
    acc(X, R, 16'h8123, 8'h00, 8'h3C);
    acc(X, W, 16'h84FE, 8'h77, 8'h00);
    acc(X, R, 16'h84FE, 8'h00, 8'h77);
    $display("test map done");
    acc(S, W, BLK, 8'h01, 8'h00);
    acc(S, W, ROW, 8'h00, 8'h00);
    acc(S, W, COL, 8'h26, 8'h00);
    for (int i = 0; i < 3; i++) acc(S, W, DAT, 8'hC0 + 8'(i), 8'h00);
    acc(S, R, BLK, 8'h00, 8'h01);
    acc(S, R, ROW, 8'h00, 8'h01);
    acc(S, R, COL, 8'h00, 8'h01);
    acc(X, R, 16'h27FE, 8'h00, 8'hC0);
    acc(X, R, 16'h27FF, 8'h00, 8'hC1);
    acc(X, R, 16'h2420, 8'h00, 8'hC2);
    acc(S, R, DAT, 8'h00, 8'h20);
    acc(S, W, BLK, 8'h00, 8'h00);
    acc(S, W, ROW, 8'h19, 8'h00);
    acc(S, W, COL, 8'h16, 8'h00);
    repeat (2) acc(S, W, DAT, 8'h5D, 8'h00);
    acc(S, R, ROW, 8'h00, 8'h00);
    acc(S, R, COL, 8'h00, 8'h00);
    acc(X, R, 16'h2337, 8'h00, 8'h5D);
    $display("test register path done");
    far(W, 14'h0005, 8'h9E, 8'h00);
    fork
      far(R, 14'h0005, 8'h00, 8'h9E);
      acc(X, R, 16'h2005, 8'h00, 8'h9E);
    join
    acc(X, W, 16'h2006, 8'h4B, 8'h00);
    far(R, 14'h0006, 8'h00, 8'h4B);
    $display("test sharing done");
    acc(X, W, 16'h0100, 8'h6E, 8'h00);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    acc(X, R, 16'h0100, 8'h00, 8'h6E);
    acc(X, R, 16'h2123, 8'h00, 8'h20);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : test_sdm_mem_if

bind sdm_mem_if sdm_mem_if_assertions chk_i (.*);
`default_nettype wire
